// >>> design/sgl_map.vh
// Constants and functional notes for the serial gain word loader
// Functional notes
// - Rising load window edge copies shift register to gain latch and stops shifting.
// - Falling load window edge holds gain latch and enables serial shifting.
// - Rising serial clock captures bit into master; falling edge moves it to slave.
// - Power-down input low powers down; high powers up.
// - Sleep input low gives sleep with output high impedance; high operates.
// - Shift register is seven bits; first-sent MSB drops out on eighth clock.
`ifndef SGL_MAP_VH
`define SGL_MAP_VH
`define SGL_SHIFT_W 7
`define SGL_WORD_W 8
`define SGL_GAIN_RST 7'h00
`define SGL_MAX_CODE 7'h47
`endif

// >>> design/sgl_loader.v
// Serial gain word loader: load window, shift register, gain latch, power controls
`timescale 1ns/1ps
`include "sgl_map.vh"
module sgl_loader #(
    parameter SHIFT_W = `SGL_SHIFT_W    // Attenuator shift register and latch width
) (
    input wire mclk,                    // System clock, 100 MHz
    input wire nrst,                    // Synchronous reset, active low
    input wire load_window_n,           // Load window pin, active low
    input wire serial_gain_in,          // Serial data pin
    input wire serial_clk,              // Serial clock pin, sampled
    input wire amp_disable_n,           // Power-down pin, active low
    input wire sleep_n,                 // Sleep pin, active low
    output reg [SHIFT_W-1:0] gain_code_r, // Latched attenuator code
    output reg gain_update_r,           // One-cycle pulse on gain update
    output reg powered_up_r,            // Amplifier fully powered
    output reg power_down_r,            // Power-down state
    output reg sleep_r,                 // Sleep state
    output reg out_enable_r,            // Output driven; low means high impedance
    output reg loading_r                // Shift register accepting bits
);

    ////////////////////////////////////////////////////////////////////////
    // Load window states

    localparam ST_IDLE = 2'h1;
    localparam ST_LOAD = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Edge and shift helpers

    function rise_of(input cur, input prev);
        begin
            rise_of = cur & ~prev;
        end
    endfunction

    function fall_of(input cur, input prev);
        begin
            fall_of = ~cur & prev;
        end
    endfunction

    function [SHIFT_W-1:0] shift_in(input [SHIFT_W-1:0] word, input bit_in);
        begin
            shift_in = {word[SHIFT_W-2:0], bit_in};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    reg [1:0] win_s_r;
    reg [1:0] dat_s_r;
    reg [1:0] clk_s_r;
    reg [1:0] pd_s_r;
    reg [1:0] sl_s_r;
    reg win_d_r;
    reg clk_d_r;
    reg master_r;
    reg [SHIFT_W-1:0] shift_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;

    wire win;
    wire sclk;
    wire sdat;
    wire win_rise;
    wire win_fall;
    wire clk_rise;
    wire clk_fall;
    wire capture_en;
    wire shift_en;

    ////////////////////////////////////////////////////////////////////////
    // Synchronised pins and their edges

    assign win = win_s_r[1];
    assign sclk = clk_s_r[1];
    assign sdat = dat_s_r[1];
    assign win_rise = rise_of(win, win_d_r);
    assign win_fall = fall_of(win, win_d_r);
    assign clk_rise = rise_of(sclk, clk_d_r);
    assign clk_fall = fall_of(sclk, clk_d_r);

    // Serial clock edges count only inside an open load window
    assign capture_en = state_r[1] & ~win & clk_rise;
    assign shift_en = state_r[1] & ~win & clk_fall;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; window idles high so no false edge after reset

    always @(posedge mclk) begin
        if (!nrst) begin
            win_s_r <= 2'h3;
            dat_s_r <= 2'h0;
            clk_s_r <= 2'h0;
            pd_s_r <= 2'h0;
            sl_s_r <= 2'h0;
        end else begin
            win_s_r <= {win_s_r[0], load_window_n};
            dat_s_r <= {dat_s_r[0], serial_gain_in};
            clk_s_r <= {clk_s_r[0], serial_clk};
            pd_s_r <= {pd_s_r[0], amp_disable_n};
            sl_s_r <= {sl_s_r[0], sleep_n};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detector history

    always @(posedge mclk) begin
        if (!nrst) begin
            win_d_r <= 1'h1;
            clk_d_r <= 1'h0;
        end else begin
            win_d_r <= win;
            clk_d_r <= sclk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Load window state machine

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (win_fall) begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (win_rise) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            loading_r <= 1'h0;
        end else begin
            loading_r <= state_nxt[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Master stage: rising serial clock captures the bit

    always @(posedge mclk) begin
        if (!nrst) begin
            master_r <= 1'h0;
        end else if (capture_en) begin
            master_r <= sdat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slave stage: falling serial clock shifts; oldest bit falls off the top

    always @(posedge mclk) begin
        if (!nrst) begin
            shift_r <= `SGL_GAIN_RST;
        end else if (shift_en) begin
            shift_r <= shift_in(shift_r, master_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gain latch: only a window rise moves it, power states never do

    always @(posedge mclk) begin
        if (!nrst) begin
            gain_code_r <= `SGL_GAIN_RST;
        end else if (win_rise) begin
            gain_code_r <= shift_r;
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            gain_update_r <= 1'h0;
        end else begin
            gain_update_r <= win_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-down control

    always @(posedge mclk) begin
        if (!nrst) begin
            power_down_r <= 1'h0;
        end else begin
            power_down_r <= ~pd_s_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep control; output goes high impedance while asleep

    always @(posedge mclk) begin
        if (!nrst) begin
            sleep_r <= 1'h0;
            out_enable_r <= 1'h0;
        end else begin
            sleep_r <= ~sl_s_r[1];
            out_enable_r <= sl_s_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fully powered only when neither control holds the part down

    always @(posedge mclk) begin
        if (!nrst) begin
            powered_up_r <= 1'h0;
        end else begin
            powered_up_r <= pd_s_r[1] & sl_s_r[1];
        end
    end

endmodule // sgl_loader

// >>> tb/sgl_loader_assertions.sv
// Checker of the gain loader ports
`timescale 1ns/1ps
module sgl_chk (
    input wire mclk,              // System clock
    input wire nrst,              // Synchronous reset, active low
    input wire load_window_n,     // Load window pin
    input wire serial_gain_in,    // Serial data pin
    input wire serial_clk,        // Serial clock pin
    input wire amp_disable_n,     // Power-down pin
    input wire sleep_n,           // Sleep pin
    input wire [6:0] gain_code_r, // Latched code
    input wire gain_update_r,     // Update pulse
    input wire powered_up_r,      // Powered state
    input wire power_down_r,      // Power-down state
    input wire sleep_r,           // Sleep state
    input wire out_enable_r,      // Output enable
    input wire loading_r          // Shift window open
);
default clocking @(posedge mclk); endclocking
default disable iff (!nrst);
upd_pulse_a: assert property (gain_update_r|=>!gain_update_r) else $error("long pulse");
code_hold_a: assert property ($changed(gain_code_r)|->gain_update_r) else $error("code moved");
load_rise_a: assert property ($rose(load_window_n)|->##[2:5] gain_update_r) else $error("no load");
load_fall_a: assert property ($fell(load_window_n)|->##[2:5] loading_r) else $error("no shift");
idle_quiet_a: assert property (load_window_n[*8]|->!gain_update_r) else $error("stray load");
pwr_down_a: assert property ($fell(amp_disable_n)|->##[2:4] power_down_r) else $error("no pd");
sleep_out_a: assert property ($fell(sleep_n)|->##[2:4] !out_enable_r) else $error("no hiz");
endmodule // sgl_chk
bind sgl_loader sgl_chk u_chk(.*);

// >>> tb/sgl_host_model.sv
// Host model driving the serial gain pins
`timescale 1ns/1ps
module sgl_host(output reg win_n=1,sd=0,sck=0);
task send(input [7:0] w); integer k; begin
win_n=0; #200;
for(k=7;k>=0;k--) begin sd=w[k]; #30 sck=1; #62.5 sck=0; #32.5; end
#100 win_n=1; sd=~sd; #300; end endtask
endmodule // sgl_host

// >>> tb/sgl_loader_bench.sv
// Random and corner tests of the gain loader
`timescale 1ns/1ps
module sgl_loader_bench;
reg mclk=0,nrst=0,pd_n=1,sl_n=1;
reg [31:0] rs=61;
reg [7:0] b;
integer fails=0,total_checks=0,i;
wire w,d,c,pu,pd,sr,oe,up,ld;
wire [6:0] g;
sgl_host u_host(.win_n(w),.sd(d),.sck(c));
sgl_loader u_dut(.mclk(mclk),.nrst(nrst),.load_window_n(w),.serial_gain_in(d),.serial_clk(c),.amp_disable_n(pd_n),
.sleep_n(sl_n),.gain_code_r(g),.gain_update_r(up),.powered_up_r(pu),.power_down_r(pd),.sleep_r(sr),.out_enable_r(oe),
.loading_r(ld));
function [31:0] xs(input [31:0] x); x^=x<<13; x^=x>>17; xs=x^(x<<5); endfunction
function [6:0] eg(input [7:0] v); eg=v[6:0]; endfunction
function [7:0] pick(input [31:0] r); pick={r[7],r[6:0]%7'h48}; endfunction
task chk(input [31:0] n,input [6:0] s,e); begin total_checks++;
if(s!==e) begin fails++; $display("Error %s exp %h got %h",n,e,s); end end endtask
task final_report; begin $display("checks %0d fails %0d",total_checks,fails);
if(fails==0&&total_checks>0) $display("All tests passed");
else $display("Some tests failed");
$finish; end endtask
initial forever #5 mclk=~mclk;
initial begin #400000; fails++; final_report; end
initial begin repeat(20) @(posedge mclk); #1 nrst=1; repeat(4) @(posedge mclk);
for(i=0;i<12;i++) begin rs=xs(rs); b=i==0?8'hC7:i==1?8'h80:pick(rs);
u_host.send(b); @(posedge mclk); #1 chk("gain",g,eg(b));
chk("load",{6'h00,ld},7'h00);
chk("upd",{6'h00,up},7'h00);
{pd_n,sl_n}=rs[9:8]; repeat(6) @(posedge mclk); #1 chk("pwr",{pu,pd,sr,oe},{pd_n&sl_n,!pd_n,!sl_n,sl_n});
chk("keep",g,eg(b));
$display("test %0d done",i); end
final_report; end
endmodule // sgl_loader_bench
